/* design/cfc_pkg.sv */
// Shared constants and types for the configuration and calibration controller
package cfc_pkg;
    // Clock rate and the 1 ms time base
    localparam int CFC_CLK_HZ      = 250_000_000;
    localparam int CFC_TICK_MS     = 1;
    localparam int CFC_TICK_CYCLES = CFC_CLK_HZ / 1000 * CFC_TICK_MS;
    // Debounce time and LED timing, all in ms
    localparam int CFC_DEB_MS   = 10;
    localparam int CFC_RAPID_MS = 50;
    localparam int CFC_FAST_MS  = 125;
    localparam int CFC_SLOW_MS  = 500;
    localparam int CFC_CNT_MS   = 250;
    localparam int CFC_PAUSE_MS = 1500;
    // Section select, ordered {sw5, sw6, sw7}
    localparam logic [2:0] CFC_SEC_CUT = 3'h3;
    localparam logic [2:0] CFC_SEC_MIN = 3'h5;
    localparam logic [2:0] CFC_SEC_FS  = 3'h7;
    // Rotary positions with special meaning
    localparam logic [3:0] CFC_ROT_SAVE = 4'h0;
    localparam logic [3:0] CFC_ROT_DIR  = 4'h9;
    localparam logic [3:0] CFC_ROT_MAX  = 4'h9;
    // Cut-out setting: reset code, multiplier shift and fixed times in us
    localparam logic [3:0]  CFC_CUT_RST    = 4'h0;
    localparam int          CFC_CUT_SHIFT  = 10;
    localparam logic [3:0]  CFC_CUT_ZERO_N = 4'ha;
    localparam logic [23:0] CFC_CUT_MIN_US = 24'h009c40;
    localparam logic [23:0] CFC_CUT_MAX_US = 24'h989680;
    localparam logic [23:0] CFC_CUT_US [1:9] = '{
        24'h002710, 24'h004e20, 24'h00c350, 24'h0186a0, 24'h030d40,
        24'h07a120, 24'h0f4240, 24'h4c4b40, 24'h989680};
    // Factory calibration per output mode, in DAC codes
    localparam logic [15:0] CFC_FAC_MIN [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h2e18};
    localparam logic [15:0] CFC_FAC_FS  [4] = '{16'h7340, 16'he678, 16'he678, 16'he678};
    localparam logic [15:0] CFC_ABS_MIN = 16'h0000;
    // Step sizes for rotary positions 1..8, in DAC codes
    localparam logic [15:0] CFC_STEP [1:8] = '{
        16'h0012, 16'h001e, 16'h003b, 16'h0094,
        16'h0127, 16'h024e, 16'h049c, 16'h0938};
    // Operating states
    typedef enum logic [4:0] {
        CFC_ST_RUN   = 5'h01,
        CFC_ST_CSHOW = 5'h02,
        CFC_ST_CEDIT = 5'h04,
        CFC_ST_CVIEW = 5'h08,
        CFC_ST_CADJ  = 5'h10
    } cfc_state_type;
endpackage

/* design/cfc_debounce.sv */
// Synchroniser and debouncer for the switch and push-button inputs
`timescale 1ns/1ps
module cfc_debounce import cfc_pkg::*; #(
    parameter int W      = 9,
    parameter int DEB_MS = CFC_DEB_MS
) (
    input  wire logic         clk,   // System clock
    input  wire logic         srst,  // Synchronous reset
    input  wire logic         tick,  // 1 ms enable
    input  wire logic [W-1:0] raw,   // Raw pin levels
    output wire logic [W-1:0] level, // Debounced levels
    output wire logic [W-1:0] rise   // One-cycle rising-edge pulses
);
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic        s1_r;
        logic        s2_r;
        logic        lvl_r;
        logic        rise_r;
        logic [11:0] cnt_r;
        // Two-flop synchroniser; s1_r feeds only s2_r
        always_ff @(posedge clk) begin
            if (srst) begin
                s1_r <= 1'b0;
                s2_r <= 1'b0;
            end else begin
                s1_r <= raw[i];
                s2_r <= s1_r;
            end
        end
        // Level must hold for DEB_MS ticks; bounce restarts the count
        always_ff @(posedge clk) begin
            if (srst) begin
                cnt_r  <= '0;
                lvl_r  <= 1'b0;
                rise_r <= 1'b0;
            end else begin
                rise_r <= 1'b0;
                if (s2_r == lvl_r) begin
                    cnt_r <= '0;
                end else if (tick) begin
                    if (cnt_r == 12'(DEB_MS - 1)) begin
                        cnt_r  <= '0;
                        lvl_r  <= s2_r;
                        rise_r <= s2_r;  // Exactly one pulse per press
                    end else begin
                        cnt_r <= cnt_r + 12'h001;
                    end
                end
            end
        end
        assign level[i] = lvl_r;
        assign rise[i]  = rise_r;
    end
endmodule

/* design/cfc_config_ui.sv */
// Configuration and calibration operator controller
`timescale 1ns/1ps
module cfc_config_ui import cfc_pkg::*; #(
    parameter int TICK_CYCLES = CFC_TICK_CYCLES,
    parameter int DEB_MS      = CFC_DEB_MS,
    parameter int RAPID_MS    = CFC_RAPID_MS,
    parameter int FAST_MS     = CFC_FAST_MS,
    parameter int SLOW_MS     = CFC_SLOW_MS,
    parameter int CNT_MS      = CFC_CNT_MS,
    parameter int PAUSE_MS    = CFC_PAUSE_MS
) (
    input  wire logic        clk,             // System clock, 250 MHz
    input  wire logic        srst,            // Synchronous reset, active high
    input  wire logic [3:0]  cfg_sw_in,       // DIP switches 4..7, bit 0 is switch 4
    input  wire logic [3:0]  rotary_in,       // Rotary switch code
    input  wire logic        button_in,       // Push-button, high when pressed
    input  wire logic [1:0]  op_mode,         // Selected output mode 0..3
    input  wire logic [19:0] range_period_us, // Input range period in us
    input  wire logic        below_zero,      // Input below zero-frequency point
    input  wire logic        input_act,       // Input activity for green LED in run
    output logic             green_led,       // Green input LED
    output logic             red_led,         // Red output LED
    output logic [3:0]       cut_code,        // Stored cut-out code
    output logic [23:0]      cutout_us,       // Cut-out time in us
    output logic [15:0]      cal_min,         // Live minimum output code
    output logic [15:0]      cal_fs,          // Live full-scale output code
    output logic             cal_dir_down,    // Adjustment direction is down
    output logic             user_cal_valid   // User calibration in force
);
    logic [17:0]   tick_cnt_r;
    logic          tick_r;
    logic [8:0]    db_lvl;
    logic [8:0]    db_rise;
    logic          press;
    logic          cfg_on;
    logic [2:0]    sec;
    logic [3:0]    rot;
    logic          cfg_prev_r;
    logic [2:0]    sec_prev_r;
    logic          entry;
    cfc_state_type state_r;
    logic [3:0]    cut_code_r;
    logic [23:0]   cutout_us_r;
    logic [29:0]   prod;
    logic          err_r;
    logic          dir_down_r;
    logic [15:0]   wk_min_r;
    logic [15:0]   wk_fs_r;
    logic [15:0]   sv_min_r;
    logic [15:0]   sv_fs_r;
    logic          user_ok_r;
    logic [1:0]    user_mode_r;
    logic [1:0]    mode_prev_r;
    logic          adj_r;
    logic [1:0]    zero_cnt_r;
    logic [15:0]   fac_min;
    logic [15:0]   fac_fs;
    logic [16:0]   cap;
    logic [15:0]   eff_min;
    logic [15:0]   eff_fs;
    logic [15:0]   adj_val;
    logic          adj_err;
    logic          is_step;
    logic [11:0]   ph_cnt_r;
    logic [11:0]   ph_lim;
    logic [4:0]    slot_r;
    logic [4:0]    two_n;
    logic          green_r;
    logic [11:0]   rb_cnt_r;
    logic          rb_r;
    logic          red_r;
    logic          green_q_r;
    cfc_state_type st_prev_r;

    // 1 ms enable drives every slow timer
    always_ff @(posedge clk) begin
        if (srst || tick_r) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 18'h00001;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= (tick_cnt_r == 18'(TICK_CYCLES - 2));
        end
    end

    // Operator inputs: {button, rotary, switches}
    cfc_debounce #(.W(9), .DEB_MS(DEB_MS)) u_deb (
        .clk   (clk),
        .srst  (srst),
        .tick  (tick_r),
        .raw   ({button_in, rotary_in, cfg_sw_in}),
        .level (db_lvl),
        .rise  (db_rise)
    );
    assign press  = db_rise[8];
    assign rot    = db_lvl[7:4];
    assign cfg_on = db_lvl[0];
    assign sec    = {db_lvl[1], db_lvl[2], db_lvl[3]};
    assign entry  = cfg_on && (!cfg_prev_r || sec != sec_prev_r);

    // Remember switch state to spot section entry
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_prev_r <= 1'b0;
            sec_prev_r <= '0;
        end else begin
            cfg_prev_r <= cfg_on;
            sec_prev_r <= sec;
        end
    end

    // Section state machine
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= CFC_ST_RUN;
        end else if (!cfg_on) begin
            state_r <= CFC_ST_RUN;
        end else if (entry) begin
            case (sec)
                CFC_SEC_CUT: state_r <= CFC_ST_CSHOW;
                CFC_SEC_MIN: state_r <= CFC_ST_CVIEW;
                CFC_SEC_FS:  state_r <= CFC_ST_CVIEW;
                default:     state_r <= CFC_ST_RUN;
            endcase
        end else if (press) begin
            case (state_r)
                CFC_ST_CSHOW: state_r <= CFC_ST_CEDIT;
                CFC_ST_CEDIT: begin
                    if (rot <= CFC_ROT_MAX) begin
                        state_r <= CFC_ST_CSHOW;
                    end
                end
                CFC_ST_CVIEW: state_r <= CFC_ST_CADJ;
                default:      state_r <= state_r;
            endcase
        end
    end

    // Stored cut-out code; invalid positions leave it unchanged
    always_ff @(posedge clk) begin
        if (srst) begin
            cut_code_r <= CFC_CUT_RST;
        end else if (state_r == CFC_ST_CEDIT && press && rot <= CFC_ROT_MAX) begin
            cut_code_r <= rot;
        end
    end

    // Cut-out time: code 0 scales the range period, clamped
    assign prod = {range_period_us, 10'h000};
    always_ff @(posedge clk) begin
        if (srst) begin
            cutout_us_r <= CFC_CUT_MIN_US;
        end else if (cut_code_r != 4'h0) begin
            cutout_us_r <= CFC_CUT_US[cut_code_r];
        end else if (prod < 30'(CFC_CUT_MIN_US)) begin
            cutout_us_r <= CFC_CUT_MIN_US;
        end else if (prod > 30'(CFC_CUT_MAX_US)) begin
            cutout_us_r <= CFC_CUT_MAX_US;
        end else begin
            cutout_us_r <= prod[23:0];
        end
    end

    // Calibration sources: factory table, 10% cap, stored values
    assign fac_min = CFC_FAC_MIN[op_mode];
    assign fac_fs  = CFC_FAC_FS[op_mode];
    assign cap     = {1'b0, fac_fs} + 17'({1'b0, fac_fs} / 17'h0000a);
    assign eff_min = (user_ok_r && user_mode_r == op_mode) ? sv_min_r : fac_min;
    assign eff_fs  = (user_ok_r && user_mode_r == op_mode) ? sv_fs_r : fac_fs;
    assign is_step = (rot != CFC_ROT_SAVE) && (rot < CFC_ROT_DIR);

    // One adjustment step with its limit checks
    always_comb begin
        logic [16:0] base;
        logic [16:0] stp;
        logic [16:0] up;
        logic [16:0] dn;
        base    = (sec == CFC_SEC_MIN) ? {1'b0, wk_min_r} : {1'b0, wk_fs_r};
        stp     = is_step ? {1'b0, CFC_STEP[rot]} : 17'h00000;
        up      = base + stp;
        dn      = base - stp;
        adj_val = dn[15:0];
        adj_err = 1'b0;
        if (sec == CFC_SEC_MIN) begin
            if (!dir_down_r) begin
                adj_val = up[15:0];
                if (up > {1'b0, wk_fs_r}) begin
                    adj_val = wk_fs_r;
                    adj_err = 1'b1;
                end
            end else if (stp > base) begin
                adj_val = CFC_ABS_MIN;
                adj_err = 1'b1;
            end
        end else begin
            if (!dir_down_r) begin
                adj_val = up[15:0];
                if (up > cap) begin
                    adj_val = cap[15:0];
                    adj_err = 1'b1;
                end
            end else if (stp > base || dn < {1'b0, wk_min_r}) begin
                adj_val = wk_min_r;
                adj_err = 1'b1;
            end
        end
    end

    // Live and stored calibration values
    always_ff @(posedge clk) begin
        if (srst) begin
            wk_min_r    <= CFC_FAC_MIN[0];
            wk_fs_r     <= CFC_FAC_FS[0];
            sv_min_r    <= CFC_FAC_MIN[0];
            sv_fs_r     <= CFC_FAC_FS[0];
            user_ok_r   <= 1'b0;
            user_mode_r <= '0;
            mode_prev_r <= '0;
            adj_r       <= 1'b0;
            zero_cnt_r  <= '0;
        end else begin
            mode_prev_r <= op_mode;
            if (op_mode != mode_prev_r) begin
                user_ok_r <= 1'b0;
                wk_min_r  <= fac_min;
                wk_fs_r   <= fac_fs;
            end else if (state_r != CFC_ST_CADJ || entry) begin
                // Unsaved steps are dropped on leaving the routine
                wk_min_r   <= eff_min;
                wk_fs_r    <= eff_fs;
                adj_r      <= 1'b0;
                zero_cnt_r <= '0;
            end else if (press && is_step) begin
                adj_r      <= 1'b1;
                zero_cnt_r <= '0;
                if (sec == CFC_SEC_MIN) begin
                    wk_min_r <= adj_val;
                end else begin
                    wk_fs_r <= adj_val;
                end
            end else if (press && rot == CFC_ROT_SAVE) begin
                adj_r <= 1'b0;
                if (!adj_r && zero_cnt_r == 2'h1) begin
                    wk_min_r  <= fac_min;
                    wk_fs_r   <= fac_fs;
                    user_ok_r <= 1'b0;
                end else begin
                    sv_min_r    <= wk_min_r;
                    sv_fs_r     <= wk_fs_r;
                    user_mode_r <= op_mode;
                    user_ok_r   <= 1'b1;
                end
                if (zero_cnt_r != 2'h3) begin
                    zero_cnt_r <= zero_cnt_r + 2'h1;
                end
            end
        end
    end

    // Direction resets to up on entry, toggles at position 9
    always_ff @(posedge clk) begin
        if (srst || entry) begin
            dir_down_r <= 1'b0;
        end else if (state_r == CFC_ST_CADJ && press && rot == CFC_ROT_DIR) begin
            dir_down_r <= ~dir_down_r;
        end
    end

    // Error flag: set by an invalid press, cleared by a later valid press
    always_ff @(posedge clk) begin
        if (srst || !cfg_on || entry) begin
            err_r <= 1'b0;
        end else if (press && state_r == CFC_ST_CEDIT) begin
            err_r <= (rot > CFC_ROT_MAX);
        end else if (press && state_r == CFC_ST_CADJ) begin
            err_r <= (is_step && adj_err) || rot > CFC_ROT_MAX;
        end
    end

    // Green LED timer: count display or steady blink per state
    assign two_n = (cut_code_r == 4'h0) ? {CFC_CUT_ZERO_N, 1'b0} : {cut_code_r, 1'b0};
    always_comb begin
        case (state_r)
            CFC_ST_CSHOW: ph_lim = (slot_r == two_n) ? 12'(PAUSE_MS) : 12'(CNT_MS);
            CFC_ST_CEDIT: ph_lim = 12'(RAPID_MS);
            CFC_ST_CVIEW: ph_lim = 12'(SLOW_MS);
            CFC_ST_CADJ:  ph_lim = 12'(FAST_MS);
            default:      ph_lim = 12'(SLOW_MS);
        endcase
    end
    always_ff @(posedge clk) begin
        if (srst || state_r != st_prev_r || (press && state_r == CFC_ST_CSHOW)) begin
            ph_cnt_r <= '0;
            slot_r   <= '0;
            green_r  <= 1'b1;  // Start lit so the first round shows all N blinks
        end else if (tick_r) begin
            if (ph_cnt_r >= ph_lim - 12'h001) begin
                ph_cnt_r <= '0;
                if (state_r == CFC_ST_CSHOW) begin
                    // Blink N times, pause, repeat
                    slot_r  <= (slot_r == two_n) ? 5'h00 : slot_r + 5'h01;
                    green_r <= (slot_r == two_n) || (slot_r[0] && slot_r + 5'h01 != two_n);
                end else begin
                    green_r <= ~green_r;
                end
            end else begin
                ph_cnt_r <= ph_cnt_r + 12'h001;
            end
        end
    end

    // Rapid blink phase for red error indication
    always_ff @(posedge clk) begin
        if (srst) begin
            rb_cnt_r <= '0;
            rb_r     <= 1'b0;
        end else if (tick_r) begin
            if (rb_cnt_r >= 12'(RAPID_MS - 1)) begin
                rb_cnt_r <= '0;
                rb_r     <= ~rb_r;
            end else begin
                rb_cnt_r <= rb_cnt_r + 12'h001;
            end
        end
    end

    // LED outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            st_prev_r <= CFC_ST_RUN;
            red_r     <= 1'b0;
            green_q_r <= 1'b0;
        end else begin
            st_prev_r <= state_r;
            green_q_r <= (state_r == CFC_ST_RUN) ? input_act : green_r;
            if (state_r == CFC_ST_RUN) begin
                red_r <= below_zero;
            end else if (err_r) begin
                red_r <= rb_r;
            end else if (state_r == CFC_ST_CADJ) begin
                red_r <= dir_down_r;
            end else begin
                red_r <= 1'b0;
            end
        end
    end

    assign green_led      = green_q_r;
    assign red_led        = red_r;
    assign cut_code       = cut_code_r;
    assign cutout_us      = cutout_us_r;
    assign cal_min        = wk_min_r;
    assign cal_fs         = wk_fs_r;
    assign cal_dir_down   = dir_down_r;
    assign user_cal_valid = user_ok_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_CUT_CAPTURE: assert property (
        state_r == CFC_ST_CEDIT && press && rot == 4'h3 |=> cut_code_r == 4'h3)
        else $error("cut-out code not captured");
    AST_CUT_BOUND: assert property (
        cut_code_r == 4'h0 && $past(cut_code_r) == 4'h0 |->
        cutout_us_r >= CFC_CUT_MIN_US && cutout_us_r <= CFC_CUT_MAX_US)
        else $error("cut-out time out of bounds");
    AST_DIR_ENTRY: assert property (
        entry |=> !dir_down_r)
        else $error("direction not up on entry");
    AST_DIR_TOGGLE: assert property (
        state_r == CFC_ST_CADJ && press && rot == CFC_ROT_DIR && !entry |=>
        dir_down_r != $past(dir_down_r))
        else $error("direction did not toggle");
    AST_RED_DIR: assert property (
        cfg_on && state_r == CFC_ST_CADJ && !err_r |=> red_r == $past(dir_down_r))
        else $error("red LED does not show direction");
    AST_MIN_LE_FS: assert property (
        wk_min_r <= wk_fs_r)
        else $error("minimum above full scale");
    AST_FS_CAP: assert property (
        op_mode == $past(op_mode) |-> {1'b0, wk_fs_r} <= cap)
        else $error("full scale above cap");
    AST_MODE_DROP: assert property (
        op_mode != mode_prev_r |=> !user_ok_r ##1 wk_fs_r == CFC_FAC_FS[$past(op_mode)])
        else $error("user calibration kept after mode change");
    AST_EXIT_RUN: assert property (
        !cfg_on |=> state_r == CFC_ST_RUN)
        else $error("configuration not left");
endmodule

/* testbench/cfc_operator.sv */
// Operator model: DIP bank, rotary switch and a chattering push-button
`timescale 1ns/1ps
module cfc_operator (
    input  wire logic       clk,       // System clock
    output logic      [3:0] cfg_sw_in, // DIP switches 4..7
    output logic      [3:0] rotary_in, // Rotary code
    output logic            button_in  // Push-button, high pressed
);
    initial begin
        cfg_sw_in = 4'h0;
        rotary_in = 4'h0;
        button_in = 1'b0;
    end
    // Rotary settles first; the contact chatters briefly, far below the debounce time
    task automatic press(input logic [3:0] pos);
        rotary_in <= pos;
        repeat (40) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            button_in <= ~button_in;
            @(posedge clk);
        end
        button_in <= 1'b1;
        repeat (40) @(posedge clk);
        button_in <= 1'b0;
        repeat (40) @(posedge clk);
    endtask
    // New switch pattern, held long enough to pass the debouncer
    task automatic set_sw(input logic [3:0] v);
        cfg_sw_in <= v;
        repeat (40) @(posedge clk);
    endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the configuration and calibration controller
`timescale 1ns/1ps
module tb import cfc_pkg::*;;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [1:0]  op_mode = 2'h1;
    logic [19:0] range_period_us = 20'h00064;
    logic        below_zero = 1'b0;
    logic        input_act = 1'b0;
    logic [3:0]  cfg_sw_in, rotary_in, cut_code, c;
    logic        button_in, green_led, red_led, cal_dir_down, user_cal_valid, seen;
    logic [23:0] cutout_us;
    logic [15:0] cal_min, cal_fs, emin, efs;
    int          miscompares = 0, n_compared = 0, seed = 94, cycles = 0;
    int          nb, nblk;
    always #2 clk = ~clk;
    cfc_operator u_op (.clk(clk), .cfg_sw_in(cfg_sw_in), .rotary_in(rotary_in),
        .button_in(button_in));
    // Short time base; fast and slow blinks keep their default tick counts
    cfc_config_ui #(.TICK_CYCLES(4), .DEB_MS(2), .RAPID_MS(2),
        .CNT_MS(2), .PAUSE_MS(6)) u_dut (.clk(clk), .srst(srst), .cfg_sw_in(cfg_sw_in),
        .rotary_in(rotary_in), .button_in(button_in), .op_mode(op_mode),
        .range_period_us(range_period_us), .below_zero(below_zero), .input_act(input_act),
        .green_led(green_led), .red_led(red_led), .cut_code(cut_code), .cutout_us(cutout_us),
        .cal_min(cal_min), .cal_fs(cal_fs), .cal_dir_down(cal_dir_down),
        .user_cal_valid(user_cal_valid));
    task automatic end_of_test();
        if (miscompares == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    // Green rising edges and any red light over n cycles, sampled mid-cycle
    task automatic count_green(input int n, output int cnt);
        logic prev;
        prev = green_led;
        cnt = 0;
        repeat (n) begin
            @(negedge clk);
            seen |= red_led;
            cnt += int'(green_led & ~prev);
            prev = green_led;
        end
        @(posedge clk);
    endtask
    // Cut-out time: fixed table, or 1024 periods clamped to its window
    function automatic logic [23:0] cut_exp(input logic [3:0] k, input logic [19:0] p);
        logic [33:0] t;
        t = {14'h0, p} << 10;
        if (k != 4'h0) return CFC_CUT_US[k];
        return (t < 34'h009c40) ? 24'h009c40 : (t > 34'h989680) ? 24'h989680 : t[23:0];
    endfunction
    // One adjustment press with the clamps a value may meet
    task automatic step(input logic [3:0] pos, input logic fs_sel, input logic dn);
        logic [16:0] v, cap;
        cap = {1'b0, CFC_FAC_FS[op_mode]} + CFC_FAC_FS[op_mode] / 10;
        u_op.press(pos);
        v = fs_sel ? {1'b0, efs} : {1'b0, emin};
        v = dn ? v - CFC_STEP[pos] : v + CFC_STEP[pos];
        if (!fs_sel) emin = (dn && v[16]) ? 16'h0 : (v > efs) ? efs : v[15:0];
        else efs = (!dn && v > cap) ? cap[15:0] : (dn && (v[16] || v < emin)) ? emin : v[15:0];
        check({cal_min, cal_fs}, {emin, efs});
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        check(cut_code, 4'h0);
        check({cal_min, cal_fs}, {CFC_FAC_MIN[1], CFC_FAC_FS[1]});
        u_op.set_sw(4'hd);
        u_op.press(4'h0);
        // Every code, code 0 with clamped and random range periods
        for (int k = 11; k >= 0; k--) begin
            c = (k > 9) ? 4'h0 : 4'(k);
            range_period_us <= (k == 11) ? 20'h00001 : (k == 10) ? 20'($random(seed)) :
                20'($random(seed)) & 20'h03fff;
            u_op.press(c);
            check(cut_code, c);
            check(cutout_us, cut_exp(c, range_period_us));
            // One display round: 2N slots of 2 ticks, a 6-tick pause, 4 cycles a tick
            nblk = (c == 4'h0) ? 10 : int'(c);
            count_green((2 * nblk * 2 + 6) * 4, nb);
            check(nb, nblk);
            u_op.press(4'h5);
        end
        u_op.press(4'hc);
        seen = 1'b0;
        count_green(32, nb);
        check({seen, cut_code}, 5'h10);
        check(nb, 2);
        u_op.press(4'h2);
        check(cut_code, 4'h2);
        // Minimum calibration: random rises, floor, then crossing full scale
        u_op.set_sw(4'hb);
        u_op.press(4'h0);
        check(cal_dir_down, 1'b0);
        count_green(4 * CFC_FAST_MS * 4, nb);
        check(nb, 2);
        emin = CFC_FAC_MIN[1];
        efs = CFC_FAC_FS[1];
        for (int i = 0; i < 6; i++) step(4'(1 + ($random(seed) & 7)), 1'b0, 1'b0);
        u_op.press(CFC_ROT_DIR);
        check({cal_dir_down, red_led}, 2'h3);
        for (int i = 0; i < 8; i++) step(4'h8, 1'b0, 1'b1);
        u_op.press(CFC_ROT_DIR);
        check({cal_dir_down, red_led}, 2'h0);
        for (int i = 0; i < 26; i++) step(4'h8, 1'b0, 1'b0);
        u_op.press(CFC_ROT_SAVE);
        check(user_cal_valid, 1'b1);
        // Full scale up to its ceiling, then leave unsaved and restore factory
        u_op.set_sw(4'hf);
        u_op.press(4'h0);
        check(cal_dir_down, 1'b0);
        for (int i = 0; i < 4; i++) step(4'h8, 1'b1, 1'b0);
        u_op.set_sw(4'h1);
        u_op.set_sw(4'hf);
        u_op.press(4'h0);
        u_op.press(CFC_ROT_SAVE);
        u_op.press(CFC_ROT_SAVE);
        check({user_cal_valid, cal_min, cal_fs}, {1'b0, CFC_FAC_MIN[1], CFC_FAC_FS[1]});
        emin = CFC_FAC_MIN[1];
        efs = CFC_FAC_FS[1];
        step(4'h8, 1'b1, 1'b0);
        u_op.press(CFC_ROT_SAVE);
        op_mode <= 2'h2 + 2'($random(seed) & 1);
        repeat (4) @(posedge clk);
        check({user_cal_valid, cal_min, cal_fs},
            {1'b0, CFC_FAC_MIN[op_mode], CFC_FAC_FS[op_mode]});
        // Back to normal running: red shows input below zero, green shows input activity
        u_op.set_sw(4'h0);
        for (int i = 0; i < 2; i++) begin
            below_zero <= (i == 0) ? 1'($random(seed)) : ~below_zero;
            input_act <= 1'($random(seed));
            repeat (3) @(posedge clk);
            check({red_led, green_led}, {below_zero, input_act});
        end
        end_of_test();
    end
endmodule
